// File: src/host_micro_port.sv
// Synchronous 8-bit host micro port with two strap-selected styles.
// Assumes host inputs are synchronous to mclk; the internal side
// answers reads from rd_data and accepts writes on a one-cycle strobe.
// Functional notes
// - A mode strap picks strobes with ready (0) or direction, data strobe and acknowledge (1), all sampled on rising edges.
// - Direction and store strobe share a pin, data strobe and read strobe share another, with chip select as third control.
// - Every transfer moves one 8-bit word and targets one of eight addresses by a 3-bit address.
// - Mode 0 read pulls ready low at once on read strobe and select, and releases it at edge N+3 for address 000, else N+2.
// - A mode 0 read completes only when select is sampled high on a rising edge.
// - Mode 0 write pulls ready low at once on store strobe and select, and releases it at edge N+2.
// - A mode 0 write finishes only when select is sampled high on a rising edge.
// - After a mode 0 write completes, the next write may start at its own edge N.
// - Mode 1 read drives acknowledge low at edge N+3 for address 000, else N+2.
// - A mode 1 read ends when select is sampled high, and acknowledge then returns high.
// - Mode 1 write drives acknowledge low at edge N+2.
// - A mode 1 write ends when select is sampled high, and acknowledge then returns high.
`timescale 1ns/1ps
`include "host_port_defines.svh"
module host_micro_port
    import host_port_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic mode_strap,
    input wire logic chip_select_n,
    input wire logic dir_store_n,
    input wire logic data_strobe_n,
    input wire logic [`HP_ADDR_W-1:0] port_addr,
    input wire logic [`HP_DATA_W-1:0] port_data_in,
    output logic [`HP_DATA_W-1:0] port_data_out,
    output logic port_data_oe,
    output logic ready,
    output logic transfer_acknowledge_n,
    output logic access_strobe,
    output access_t access,
    input wire logic [`HP_DATA_W-1:0] rd_data
);
    port_state_t state_q;
    port_state_t state_d;
    logic mode_q;
    logic mode_d;
    logic mode_seen_q;
    logic is_read_q;
    logic is_read_d;
    logic slow_q;
    logic slow_d;
    logic [`HP_DATA_W-1:0] dout_q;
    logic [`HP_DATA_W-1:0] dout_d;
    logic ack_n_q;
    logic ack_n_d;
    access_t acc_q;
    access_t acc_d;
    logic stb_q;
    logic stb_d;
    logic start_rd;
    logic start_wr;
    logic hit;
    logic [`HP_CNT_W-1:0] limit;

    // Decode the shared pins per style
    always_comb
    begin
        start_rd = 1'b0;
        start_wr = 1'b0;
        if (!chip_select_n)
        begin
            if (!mode_q)
            begin
                start_rd = !data_strobe_n && dir_store_n;
                start_wr = !dir_store_n && data_strobe_n;
            end
            else
            begin
                start_rd = !data_strobe_n && dir_store_n;
                start_wr = !data_strobe_n && !dir_store_n;
            end
        end
    end

    assign limit = slow_q ? `HP_WAIT_SLOW : `HP_WAIT_FAST;

    wait_counter #(
        .CW(`HP_CNT_W)
    ) u_wait (
        .mclk(mclk),
        .rst_b(rst_b),
        .ce(ce),
        .clear(state_q != ST_WAIT),
        .limit(limit),
        .hit(hit)
    );

    // Strap is caught after reset release and then held
    always_comb
    begin
        mode_d = mode_seen_q ? mode_q : mode_strap;
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mode_q <= 1'b0;
            mode_seen_q <= 1'b0;
        end
        else if (ce)
        begin
            mode_q <= mode_d;
            mode_seen_q <= 1'b1;
        end
    end

    always_comb
    begin
        state_d = state_q;
        is_read_d = is_read_q;
        slow_d = slow_q;
        dout_d = dout_q;
        ack_n_d = ack_n_q;
        acc_d = acc_q;
        stb_d = 1'b0;
        case (state_q)
            ST_IDLE:
            begin
                ack_n_d = 1'b1;
                if (mode_seen_q && (start_rd || start_wr))
                begin
                    // Edge N: sample the request
                    state_d = ST_WAIT;
                    is_read_d = start_rd;
                    slow_d = start_rd && port_addr == `HP_ADDR_INTERNAL;
                    acc_d.addr = port_addr;
                    acc_d.data = port_data_in;
                    acc_d.rd = start_rd;
                    stb_d = 1'b1;
                end
            end
            ST_WAIT:
            begin
                if (hit)
                begin
                    // Edge N+2 or N+3: answer
                    state_d = ST_DONE;
                    dout_d = rd_data;
                    ack_n_d = 1'b0;
                end
            end
            ST_DONE:
            begin
                if (chip_select_n)
                begin
                    state_d = ST_IDLE;
                    ack_n_d = 1'b1;
                end
            end
            default:
            begin
                state_d = ST_IDLE;
                ack_n_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q <= ST_IDLE;
            is_read_q <= 1'b0;
            slow_q <= 1'b0;
            dout_q <= '0;
            ack_n_q <= 1'b1;
            acc_q <= '0;
            stb_q <= 1'b0;
        end
        else if (ce)
        begin
            state_q <= state_d;
            is_read_q <= is_read_d;
            slow_q <= slow_d;
            dout_q <= dout_d;
            ack_n_q <= ack_n_d;
            acc_q <= acc_d;
            stb_q <= stb_d;
        end
    end

    // Ready drops combinationally on strobe and select until the answer
    assign ready = mode_q ? 1'b1 :
        !((state_q == ST_IDLE && (start_rd || start_wr)) ||
          state_q == ST_WAIT);
    assign transfer_acknowledge_n = mode_q ? ack_n_q : 1'b1;
    assign port_data_out = dout_q;
    assign port_data_oe = !chip_select_n && is_read_q &&
        state_q == ST_DONE && dir_store_n;
    assign access_strobe = stb_q;
    assign access = acc_q;
endmodule

// File: src/host_port_defines.svh
// Constants of the host micro port: timing counts, widths, address codes.
// Included by the package and design files; definitions only.
`ifndef HOST_PORT_DEFINES_SVH
`define HOST_PORT_DEFINES_SVH
`define HP_DATA_W 8
`define HP_ADDR_W 3
`define HP_ADDR_INTERNAL 3'h0
`define HP_WAIT_SLOW 3'h3
`define HP_WAIT_FAST 3'h2
`define HP_CNT_W 3
`endif

// File: src/host_port_pkg.sv
// Types of the host micro port.
// Assumes host_port_defines.svh is on the include path.
`include "host_port_defines.svh"
package host_port_pkg;
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_WAIT = 5'b00010,
        ST_DONE = 5'b00100,
        ST_HOLD = 5'b01000,
        ST_END  = 5'b10000
    } port_state_t;

    typedef struct packed {
        logic [`HP_ADDR_W-1:0] addr;
        logic [`HP_DATA_W-1:0] data;
        logic rd;
    } access_t;
endpackage

// File: src/wait_counter.sv
// Counts clock edges since the start of a transfer.
// Assumes clear is asserted while no transfer is open.
`timescale 1ns/1ps
`include "host_port_defines.svh"
module wait_counter
    import host_port_pkg::*;
#(
    parameter int CW = `HP_CNT_W
)
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic clear,
    input wire logic [CW-1:0] limit,
    output logic hit
);
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;

    always_comb
    begin
        cnt_d = cnt_q;
        if (clear)
            cnt_d = '0;
        else if (cnt_q != limit)
            cnt_d = cnt_q + {{(CW-1){1'b0}}, 1'b1};
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            cnt_q <= '0;
        else if (ce)
            cnt_q <= cnt_d;
    end

    // Edge limit after start is the answer edge, counting edge N as 0
    assign hit = !clear && (cnt_q == limit - {{(CW-1){1'b0}}, 1'b1});
endmodule

// File: verif/host_port_monitor.sv
// Checker of host micro port handshake timing, bound to host_micro_port.
// Assumes the mode strap only changes while reset is held.
`timescale 1ns/1ps
`include "host_port_defines.svh"
module host_port_monitor
    import host_port_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic mode_strap,
    input wire logic chip_select_n,
    input wire logic [`HP_DATA_W-1:0] port_data_in,
    input wire logic port_data_oe,
    input wire logic ready,
    input wire logic transfer_acknowledge_n,
    input wire logic access_strobe,
    input wire access_t access
);
    wire m = mode_strap;
    wire cs = chip_select_n;
    wire ak = transfer_acknowledge_n;
    wire st = access_strobe;
    wire slow = access.rd && access.addr == `HP_ADDR_INTERNAL;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    AST_ACK_SLOW: assert property (m && st && slow |-> ak[*3] ##1 !ak)
        else $error("slow read ack timing wrong");
    AST_ACK_FAST: assert property (m && st && !slow |-> ak[*2] ##1 !ak)
        else $error("fast ack timing wrong");
    AST_RDY_SLOW: assert property (!m && st && slow |-> !ready[*3] ##1 ready)
        else $error("slow read ready timing wrong");
    AST_RDY_FAST: assert property (!m && st && !slow |-> !ready[*2] ##1 ready)
        else $error("fast ready timing wrong");
    AST_ACK_RELEASE: assert property (!ak && cs |=> ak)
        else $error("ack not released after select high");
    AST_MODE0_ACK: assert property (!m |-> ak)
        else $error("ack driven in strobe style");
    AST_CS_IDLE: assert property (cs && $past(cs) |-> !st && !port_data_oe)
        else $error("activity while deselected");
    AST_WR_CAPTURE: assert property (st && !access.rd |-> access.data == $past(port_data_in))
        else $error("write data not captured");
    cover property (st && slow);
    cover property (m && !ak);
    cover property (!m && st && !access.rd);
endmodule

bind host_micro_port host_port_monitor mon (.mclk, .rst_b, .mode_strap,
    .chip_select_n, .port_data_in, .port_data_oe, .ready,
    .transfer_acknowledge_n, .access_strobe, .access);

// File: verif/host_cpu_model.sv
// Host processor model driving the micro port pins one byte at a time.
// Assumes mode_strap matches the style latched by the port.
`timescale 1ns/1ps
module host_cpu_model
(
    input wire logic mclk,
    input wire logic mode_strap,
    input wire logic ready,
    input wire logic transfer_acknowledge_n,
    input wire logic [7:0] port_data_out,
    output logic chip_select_n = 1'b1,
    output logic dir_store_n = 1'b1,
    output logic data_strobe_n = 1'b1,
    output logic [2:0] port_addr = 3'h0,
    output logic [7:0] port_data_in = 8'h00
);
    task automatic xfer(input logic rd, input logic [2:0] a,
        input logic [7:0] d, output logic [7:0] q, output int n);
        n = 0;
        @(negedge mclk);
        chip_select_n = 1'b0;
        dir_store_n = rd;
        data_strobe_n = mode_strap ? 1'b0 : !rd;
        port_addr = a;
        port_data_in = d;
        @(posedge mclk);
        @(negedge mclk);
        while (n < 8 && (mode_strap ? transfer_acknowledge_n : !ready))
        begin
            n++;
            @(negedge mclk);
        end
        q = port_data_out;
        // Strobes stay put so the next same-kind access needs no edge
        chip_select_n = 1'b1;
        port_data_in = ~d;
        port_addr = ~a;
        @(posedge mclk);
    endtask
endmodule

// File: verif/host_micro_port_handshake_tb.sv
// Bench of the host micro port in both strap styles.
// Uses host_cpu_model on the pins; the monitor is bound to the port.
`timescale 1ns/1ps
`include "host_port_defines.svh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
    miscompares++; $display("unexpected %s exp %h got %h", n, e, g); end end
module host_micro_port_handshake_tb
    import host_port_pkg::*;
;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic mode_strap = 1'b0;
    logic [7:0] rd_data = 8'h00;
    logic chip_select_n, dir_store_n, data_strobe_n, port_data_oe;
    logic ready, transfer_acknowledge_n, access_strobe;
    logic [2:0] port_addr;
    logic [7:0] port_data_in, port_data_out;
    access_t access;
    int miscompares = 0;
    int compares = 0;
    int cycles = 0;
    host_micro_port DUT (.mclk, .rst_b, .ce(1'b1), .mode_strap,
        .chip_select_n, .dir_store_n, .data_strobe_n, .port_addr,
        .port_data_in, .port_data_out, .port_data_oe, .ready,
        .transfer_acknowledge_n, .access_strobe, .access, .rd_data);
    host_cpu_model host (.mclk, .mode_strap, .ready, .transfer_acknowledge_n,
        .port_data_out, .chip_select_n, .dir_store_n, .data_strobe_n,
        .port_addr, .port_data_in);
    initial
    begin
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            miscompares++;
            summarize();
        end
    end
    task automatic summarize();
        if (miscompares == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic check_xfer(input logic rd, input logic [2:0] a,
        input logic [7:0] d, input int exp_n);
        logic [7:0] q;
        int n;
        rd_data = d;
        host.xfer(rd, a, d, q, n);
        `CHK("answer edge", exp_n, n)
        if (rd)
            `CHK("read data", d, q)
        else
            `CHK("write data", d, access.data)
    endtask
    task automatic run_style(input logic m);
        @(negedge mclk);
        rst_b = 1'b0;
        mode_strap = m;
        repeat (12) @(negedge mclk);
        rst_b = 1'b1;
        @(negedge mclk);
        check_xfer(1'b0, 3'h5, 8'ha5, 2);
        check_xfer(1'b0, 3'h0, 8'h5a, 2);
        check_xfer(1'b1, 3'h0, 8'h3c, 3);
        check_xfer(1'b1, 3'h7, 8'hc3, 2);
        host.data_strobe_n = 1'b0;
        repeat (4)
        begin
            @(negedge mclk);
            `CHK("idle", 3'b001, {access_strobe, port_data_oe, ready})
        end
    endtask
    initial
    begin
        run_style(1'b0);
        run_style(1'b1);
        summarize();
    end
endmodule
